// ---- design/uart_map.vh ----
// register offsets, field positions, reset values and timing counts for the serial port
// assumes a 40 MHz hclk and an AHB-Lite slave decode on word-aligned byte addresses
//
// What this block does
// - device sends on its transmit pin and receives on its receive pin.
// - with flow control on, request and clear lines are active low; transmit gated.
// - frames hold 8 data bits, none/odd/even parity, 1 or 2 stop bits.
// - any bit rate 1200 bps to 3 Mbps follows from the programmed rate value.
// - receive line low longer than break timeout in microseconds resets the device.
// - timeouts below 1000 count as zero; above 255000 clamp to 255000, and 255000 never fires as the low count stops there.
// - device can hold its transmit line low as a break to wake host.
// - while module reset is asserted all serial outputs float.
`ifndef UART_MAP_VH
`define UART_MAP_VH

`define CTRL_OFS 8'h00
`define RATE_OFS 8'h04
`define TMO_OFS 8'h08
`define TXDATA_OFS 8'h0C
`define RXDATA_OFS 8'h10
`define STATUS_OFS 8'h14
`define IRQ_STAT_OFS 8'h18
`define IRQ_MASK_OFS 8'h1C

// control fields
`define CTRL_PAR_LO 0
`define CTRL_PAR_HI 1
`define CTRL_STOP2 2
`define CTRL_FLOW 3
`define CTRL_BREAK 4
`define CTRL_RESET 5'h00
`define PAR_NONE 2'h0
`define PAR_ODD 2'h1
`define PAR_EVEN 2'h2

// irq status fields
`define IRQ_RX_DONE 0
`define IRQ_TX_DONE 1
`define IRQ_PAR_ERR 2
`define IRQ_FRM_ERR 3
`define IRQ_OVERRUN 4
`define IRQ_W 5

// rate value: bit rate = value / 0.004096 s; phase accumulator gives 8 ticks per bit
`define RATE_RESET 16'h01D8
`define OVERSAMPLE 8
`define ACC_MOD 20480

// break timeout in microseconds
`define TMO_RESET 18'h00000
`define TMO_MIN 1000
`define TMO_MAX 255000
`define CLK_HZ 40000000
`define US_NS 1000
`define CLK_NS 25
`define US_CYCLES (`US_NS / `CLK_NS)

`endif

// ---- design/uart_with_break_reset.v ----
// serial port with configurable framing, rts/cts gating and break-triggered self reset
// assumes a single AHB-Lite master, pins already split into in/out/enable by the pad ring
//
// Implementation choices: the AHB-Lite register port and the address map.
`include "uart_map.vh"

module uart_with_break_reset #(
    parameter RATE_W = 16
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg irq,
    input wire rx_in,
    input wire cts_n_in,
    output reg tx_out,
    output reg tx_oe,
    output reg rts_n_out,
    output reg rts_n_oe,
    output reg break_reset
);

// ---------------------------------------------------------------
// helpers
// ---------------------------------------------------------------
function par_bit;
    input [7:0] d;
    input [1:0] mode;
    begin
        par_bit = (mode == `PAR_ODD) ? ~^d : ^d;
    end
endfunction

localparam T_IDLE = 5'b00001;
localparam T_START = 5'b00010;
localparam T_DATA = 5'b00100;
localparam T_PAR = 5'b01000;
localparam T_STOP = 5'b10000;
localparam R_IDLE = 5'b00001;
localparam R_START = 5'b00010;
localparam R_DATA = 5'b00100;
localparam R_PAR = 5'b01000;
localparam R_STOP = 5'b10000;
localparam [17:0] TMO_MIN_V = `TMO_MIN;
localparam [17:0] TMO_MAX_V = `TMO_MAX;
localparam [15:0] ACC_MOD_V = `ACC_MOD;
localparam integer US_CYC = `US_CYCLES;
localparam [5:0] US_LAST = US_CYC[5:0] - 6'h01;

wire srst = break_reset;

// ---------------------------------------------------------------
// pin synchronisers
// ---------------------------------------------------------------
reg rx_meta_reg, rx_sync_reg, cts_meta_reg, cts_sync_reg;
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        rx_meta_reg <= 1'b1;
        rx_sync_reg <= 1'b1;
        cts_meta_reg <= 1'b1;
        cts_sync_reg <= 1'b1;
    end else begin
        rx_meta_reg <= rx_in;
        rx_sync_reg <= rx_meta_reg;
        cts_meta_reg <= cts_n_in;
        cts_sync_reg <= cts_meta_reg;
    end
end

// ---------------------------------------------------------------
// registers and AHB-Lite slave
// ---------------------------------------------------------------
reg [4:0] ctrl_reg;
reg [RATE_W-1:0] rate_reg;
reg [17:0] tmo_reg;
reg [7:0] txdata_reg;
reg tx_pend_reg;
reg [7:0] rxdata_reg;
reg rx_valid_reg;
reg [`IRQ_W-1:0] irq_stat_reg, irq_mask_reg;
reg wr_pend_reg;
reg [7:0] wr_addr_reg;
reg [4:0] tx_st_reg, rx_st_reg;
reg tx_start_take;
reg [`IRQ_W-1:0] irq_set;
reg rx_load;
reg [7:0] rx_load_data;

wire [1:0] par_mode = ctrl_reg[`CTRL_PAR_HI:`CTRL_PAR_LO];
wire flow_en = ctrl_reg[`CTRL_FLOW];
wire take = hsel & htrans[1] & hready;
wire rd_take = take & ~hwrite;
wire wr_now = wr_pend_reg;
wire rx_read = rd_take & (haddr[7:0] == `RXDATA_OFS);
wire tx_write = wr_now & (wr_addr_reg == `TXDATA_OFS) & ~tx_pend_reg;
wire [`IRQ_W-1:0] irq_clr = (wr_now && wr_addr_reg == `IRQ_STAT_OFS) ? hwdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

reg [31:0] rd_value;
always @* begin
    rd_value = 32'h00000000;
    if (haddr[7:0] == `CTRL_OFS) begin
        rd_value = {27'h0000000, ctrl_reg};
    end else if (haddr[7:0] == `RATE_OFS) begin
        rd_value = {{(32-RATE_W){1'b0}}, rate_reg};
    end else if (haddr[7:0] == `TMO_OFS) begin
        rd_value = {14'h0000, tmo_reg};
    end else if (haddr[7:0] == `RXDATA_OFS) begin
        rd_value = {24'h000000, rxdata_reg};
    end else if (haddr[7:0] == `STATUS_OFS) begin
        rd_value = {26'h0000000, rx_sync_reg, cts_sync_reg, rx_valid_reg, tx_pend_reg, ~tx_st_reg[0],
                    ~rx_st_reg[0]};
    end else if (haddr[7:0] == `IRQ_STAT_OFS) begin
        rd_value = {27'h0000000, irq_stat_reg};
    end else if (haddr[7:0] == `IRQ_MASK_OFS) begin
        rd_value = {27'h0000000, irq_mask_reg};
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata <= 32'h00000000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        wr_pend_reg <= 1'b0;
        wr_addr_reg <= 8'h00;
    end else begin
        // zero wait states: read data is built in the address phase
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        if (rd_take) begin
            hrdata <= rd_value;
        end
        if (hready) begin
            wr_pend_reg <= take & hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ctrl_reg <= `CTRL_RESET;
        rate_reg <= `RATE_RESET;
        tmo_reg <= `TMO_RESET;
        txdata_reg <= 8'h00;
        tx_pend_reg <= 1'b0;
        rxdata_reg <= 8'h00;
        rx_valid_reg <= 1'b0;
        irq_stat_reg <= {`IRQ_W{1'b0}};
        irq_mask_reg <= {`IRQ_W{1'b0}};
        irq <= 1'b0;
    end else if (srst) begin
        // break reset returns control, rate, timeout, flag and interrupt registers to power-on values; data and shift registers keep theirs
        ctrl_reg <= `CTRL_RESET;
        rate_reg <= `RATE_RESET;
        tmo_reg <= `TMO_RESET;
        tx_pend_reg <= 1'b0;
        rx_valid_reg <= 1'b0;
        irq_stat_reg <= {`IRQ_W{1'b0}};
        irq_mask_reg <= {`IRQ_W{1'b0}};
        irq <= 1'b0;
    end else begin
        if (wr_now && wr_addr_reg == `CTRL_OFS) begin
            ctrl_reg <= hwdata[4:0];
        end
        if (wr_now && wr_addr_reg == `RATE_OFS) begin
            rate_reg <= hwdata[RATE_W-1:0];
        end
        if (wr_now && wr_addr_reg == `TMO_OFS) begin
            tmo_reg <= hwdata[17:0];
        end
        if (wr_now && wr_addr_reg == `IRQ_MASK_OFS) begin
            irq_mask_reg <= hwdata[`IRQ_W-1:0];
        end
        // a write while a byte still waits is dropped; software polls the pending bit
        if (tx_write) begin
            txdata_reg <= hwdata[7:0];
            tx_pend_reg <= 1'b1;
        end else if (tx_start_take) begin
            tx_pend_reg <= 1'b0;
        end
        if (rx_load) begin
            rxdata_reg <= rx_load_data;
            rx_valid_reg <= 1'b1;
        end else if (rx_read) begin
            rx_valid_reg <= 1'b0;
        end
        // set wins over a same-cycle clear
        irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
        irq <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_reg);
    end
end

// ---------------------------------------------------------------
// bit-rate tick: eight ticks per bit from a phase accumulator
// ---------------------------------------------------------------
reg [15:0] acc_reg;
reg tick_reg;
wire [16:0] acc_sum = {1'b0, acc_reg} + {{(17-RATE_W){1'b0}}, rate_reg};
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        acc_reg <= 16'h0000;
        tick_reg <= 1'b0;
    end else if (srst) begin
        acc_reg <= 16'h0000;
        tick_reg <= 1'b0;
    end else if (acc_sum >= {1'b0, ACC_MOD_V}) begin
        acc_reg <= acc_sum[15:0] - ACC_MOD_V;
        tick_reg <= 1'b1;
    end else begin
        acc_reg <= acc_sum[15:0];
        tick_reg <= 1'b0;
    end
end

// ---------------------------------------------------------------
// transmitter
// ---------------------------------------------------------------
reg [2:0] tx_tk_reg;
reg [2:0] tx_bit_reg;
reg [7:0] tx_sh_reg;
reg tx_stop2_reg;
// parity is frozen at start so a byte queued mid-frame cannot alter it
reg tx_par_reg;
reg tx_line_reg;
wire cts_ok = ~flow_en | ~cts_sync_reg;
wire tx_bit_end = tick_reg & (tx_tk_reg == 3'h7);
always @* begin
    tx_start_take = tx_st_reg[0] & tx_pend_reg & cts_ok & ~ctrl_reg[`CTRL_BREAK];
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        tx_st_reg <= T_IDLE;
        tx_tk_reg <= 3'h0;
        tx_bit_reg <= 3'h0;
        tx_sh_reg <= 8'h00;
        tx_par_reg <= 1'b0;
        tx_stop2_reg <= 1'b0;
        tx_line_reg <= 1'b1;
    end else if (srst) begin
        tx_st_reg <= T_IDLE;
        tx_line_reg <= 1'b1;
    end else begin
        if (tick_reg) begin
            tx_tk_reg <= tx_tk_reg + 3'h1;
        end
        case (tx_st_reg)
            T_IDLE: begin
                tx_line_reg <= 1'b1;
                if (tx_start_take) begin
                    tx_sh_reg <= txdata_reg;
                    tx_par_reg <= par_bit(txdata_reg, par_mode);
                    tx_tk_reg <= 3'h0;
                    tx_line_reg <= 1'b0;
                    tx_st_reg <= T_START;
                end
            end
            T_START: begin
                if (tx_bit_end) begin
                    tx_line_reg <= tx_sh_reg[0];
                    tx_bit_reg <= 3'h0;
                    tx_st_reg <= T_DATA;
                end
            end
            T_DATA: begin
                if (tx_bit_end) begin
                    tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
                    tx_bit_reg <= tx_bit_reg + 3'h1;
                    if (tx_bit_reg != 3'h7) begin
                        tx_line_reg <= tx_sh_reg[1];
                    end else if (par_mode != `PAR_NONE) begin
                        tx_line_reg <= tx_par_reg;
                        tx_st_reg <= T_PAR;
                    end else begin
                        tx_line_reg <= 1'b1;
                        tx_stop2_reg <= ctrl_reg[`CTRL_STOP2];
                        tx_st_reg <= T_STOP;
                    end
                end
            end
            T_PAR: begin
                if (tx_bit_end) begin
                    tx_line_reg <= 1'b1;
                    tx_stop2_reg <= ctrl_reg[`CTRL_STOP2];
                    tx_st_reg <= T_STOP;
                end
            end
            T_STOP: begin
                if (tx_bit_end) begin
                    tx_stop2_reg <= 1'b0;
                    if (!tx_stop2_reg) begin
                        tx_st_reg <= T_IDLE;
                    end
                end
            end
            default: tx_st_reg <= T_IDLE;
        endcase
    end
end

// ---------------------------------------------------------------
// receiver: middle-of-bit sampling at tick four
// ---------------------------------------------------------------
reg [2:0] rx_tk_reg;
reg [2:0] rx_bit_reg;
reg [7:0] rx_sh_reg;
wire rx_mid = tick_reg & (rx_tk_reg == 3'h3);
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        rx_st_reg <= R_IDLE;
        rx_tk_reg <= 3'h0;
        rx_bit_reg <= 3'h0;
        rx_sh_reg <= 8'h00;
    end else if (srst) begin
        rx_st_reg <= R_IDLE;
    end else begin
        if (tick_reg) begin
            rx_tk_reg <= rx_tk_reg + 3'h1;
        end
        case (rx_st_reg)
            R_IDLE: begin
                if (!rx_sync_reg) begin
                    rx_tk_reg <= 3'h0;
                    rx_st_reg <= R_START;
                end
            end
            R_START: begin
                if (rx_mid) begin
                    rx_bit_reg <= 3'h0;
                    rx_st_reg <= rx_sync_reg ? R_IDLE : R_DATA;
                end
            end
            R_DATA: begin
                if (rx_mid) begin
                    rx_sh_reg <= {rx_sync_reg, rx_sh_reg[7:1]};
                    rx_bit_reg <= rx_bit_reg + 3'h1;
                    if (rx_bit_reg == 3'h7) begin
                        rx_st_reg <= (par_mode != `PAR_NONE) ? R_PAR : R_STOP;
                    end
                end
            end
            R_PAR: begin
                if (rx_mid) begin
                    rx_st_reg <= R_STOP;
                end
            end
            R_STOP: begin
                // only the first stop bit is checked; a second one looks like idle
                if (rx_mid) begin
                    rx_st_reg <= R_IDLE;
                end
            end
            default: rx_st_reg <= R_IDLE;
        endcase
    end
end

always @* begin
    irq_set = {`IRQ_W{1'b0}};
    rx_load = rx_st_reg[4] & rx_mid & ~srst;
    rx_load_data = rx_sh_reg;
    irq_set[`IRQ_RX_DONE] = rx_load;
    irq_set[`IRQ_OVERRUN] = rx_load & rx_valid_reg & ~rx_read;
    irq_set[`IRQ_FRM_ERR] = rx_load & ~rx_sync_reg;
    irq_set[`IRQ_PAR_ERR] = rx_st_reg[3] & rx_mid & (rx_sync_reg != par_bit(rx_sh_reg, par_mode)) & ~srst;
    irq_set[`IRQ_TX_DONE] = tx_st_reg[4] & tx_bit_end & ~tx_stop2_reg & ~srst;
end

// ---------------------------------------------------------------
// break detection and self reset
// ---------------------------------------------------------------
reg [5:0] us_cnt_reg;
reg [17:0] low_us_reg;
wire [17:0] tmo_eff = (tmo_reg < TMO_MIN_V) ? 18'h00000 : ((tmo_reg > TMO_MAX_V) ? TMO_MAX_V : tmo_reg);
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        us_cnt_reg <= 6'h00;
        low_us_reg <= 18'h00000;
        break_reset <= 1'b0;
    end else if (rx_sync_reg || srst) begin
        us_cnt_reg <= 6'h00;
        low_us_reg <= 18'h00000;
        break_reset <= 1'b0;
    end else begin
        if (us_cnt_reg == US_LAST) begin
            us_cnt_reg <= 6'h00;
            if (low_us_reg != TMO_MAX_V) begin
                low_us_reg <= low_us_reg + 18'h00001;
            end
        end else begin
            us_cnt_reg <= us_cnt_reg + 6'h01;
        end
        // a zero timeout disables the feature
        break_reset <= (tmo_eff != 18'h00000) && (low_us_reg > tmo_eff);
    end
end

// ---------------------------------------------------------------
// pin drivers
// ---------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        tx_out <= 1'b1;
        tx_oe <= 1'b0;
        rts_n_out <= 1'b1;
        rts_n_oe <= 1'b0;
    end else begin
        tx_oe <= ~srst;
        rts_n_oe <= ~srst;
        tx_out <= tx_line_reg & ~ctrl_reg[`CTRL_BREAK];
        // with flow control on, ready to take a byte only while the holding register is empty; always ready with it off
        rts_n_out <= flow_en & rx_valid_reg;
    end
end

endmodule // uart_with_break_reset

// ---- tb/uart_with_break_reset_chk.sv ----
// pin-level assertions for the serial port with break reset
// assumes binding onto the design top, with hready tied to hreadyout
module uart_with_break_reset_chk (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire rx_in,
    input wire tx_oe,
    input wire rts_n_oe,
    input wire break_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // helper: length of the current low run on rx
    // ----------------------------------------
    logic [16:0] low_cnt;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            low_cnt <= 17'h0;
        else if (rx_in)
            low_cnt <= 17'h0;
        else if (low_cnt != 17'h1FFFF)
            low_cnt <= low_cnt + 17'h1;
    end
    sequence s_float;
        !tx_oe && !rts_n_oe;
    endsequence
    sequence s_pulse;
        break_reset ##1 !break_reset;
    endsequence
    // no disable here: the rule is about the reset itself
    property p_float_in_reset;
        @(posedge hclk) !hresetn |-> s_float;
    endproperty
    property p_ready;
        @(posedge hclk) disable iff (!hresetn) hreadyout;
    endproperty
    property p_okay;
        @(posedge hclk) disable iff (!hresetn) !hresp;
    endproperty
    property p_brk_pulse;
        @(posedge hclk) disable iff (!hresetn) break_reset |-> s_pulse;
    endproperty
    property p_brk_float;
        @(posedge hclk) disable iff (!hresetn) break_reset |=> s_float;
    endproperty
    property p_brk_min;
        @(posedge hclk) disable iff (!hresetn) break_reset |-> low_cnt >= 17'h09C40;
    endproperty
    property p_oe_pair;
        @(posedge hclk) disable iff (!hresetn) tx_oe == rts_n_oe;
    endproperty
    property p_unmapped;
        @(posedge hclk) disable iff (!hresetn)
            hsel && htrans[1] && hready && !hwrite && haddr[7:0] > 8'h1C |=> hrdata == 32'h0;
    endproperty
    a_float_in_reset: assert property (p_float_in_reset) else $error("pins driven in reset");
    a_ready: assert property (p_ready) else $error("wait state inserted");
    a_okay: assert property (p_okay) else $error("error response");
    a_brk_pulse: assert property (p_brk_pulse) else $error("break pulse too long");
    a_brk_float: assert property (p_brk_float) else $error("pins driven after break");
    a_brk_min: assert property (p_brk_min) else $error("break reset too early");
    a_oe_pair: assert property (p_oe_pair) else $error("enables disagree");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // uart_with_break_reset_chk

// ---- tb/host_serial.sv ----
// behavioural host on the far side of the serial pins
// assumes the bench sets the bit period to match the programmed rate
module host_serial #(
    parameter int BIT_CYC = 64
) (
    input wire logic hclk,
    input wire logic tx_line,
    input wire logic rts_n,
    output logic rx_line,
    output logic cts_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_line = 1'b1;
        cts_n = 1'b1;
    end
    // frame bits go out lsb first; an idle line stays high
    // a frame is held back up to 4000 cycles while the device's request line is high
    task automatic send(input logic [11:0] f);
        for (int n = 0; n < 4000 && rts_n !== 1'b0; n++) @(posedge hclk);
        for (int i = 0; i < 12; i++) begin
            rx_line <= f[i];
            repeat (BIT_CYC) @(posedge hclk);
        end
    endtask
    // sampling in mid-bit tolerates a few cycles of skew
    task automatic recv(output logic [11:0] f, output bit ok);
        int n;
        f = 12'h0;
        ok = 1'b0;
        for (n = 0; n < 4000 && tx_line !== 1'b0; n++) @(posedge hclk);
        if (n < 4000) begin
            ok = 1'b1;
            repeat (BIT_CYC / 2) @(posedge hclk);
            for (int i = 0; i < 12; i++) begin
                f[i] = tx_line;
                repeat (BIT_CYC) @(posedge hclk);
            end
        end
    endtask
endmodule // host_serial

// ---- tb/tb_uart_with_break_reset.sv ----
// self-checking bench for the serial port with break reset
// assumes one clock at 40 MHz and a behavioural host on the pins
`include "uart_map.vh"
module tb_uart_with_break_reset;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, rdv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [11:0] fr;
    wire [31:0] hrdata;
    wire hreadyout, hresp, irq, tx_out, tx_oe, rts_n_out, rts_n_oe, break_reset, rx_line, cts_n;
    // weak pull-up on the pad while the port floats
    wire tx_line = tx_oe ? tx_out : 1'b1;
    wire rts_line = rts_n_oe ? rts_n_out : 1'b1;
    bit ok;
    int n_fail, n_checks, n, lows;
    uart_with_break_reset DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .rx_in(rx_line), .cts_n_in(cts_n), .tx_out(tx_out),
        .tx_oe(tx_oe), .rts_n_out(rts_n_out), .rts_n_oe(rts_n_oe), .break_reset(break_reset));
    host_serial #(.BIT_CYC(64)) host (.hclk(hclk), .tx_line(tx_line), .rts_n(rts_line), .rx_line(rx_line),
        .cts_n(cts_n));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task end_of_test;
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task hwait;
        int i;
        @(posedge hclk);
        for (i = 0; i < 50 && hreadyout !== 1'b1; i++) @(posedge hclk);
        if (i == 50) begin
            n_fail++;
            end_of_test;
        end
    endtask
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hwait;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        hwait;
        rdv = hrdata;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rdv, exp);
    endtask
    task get_frame(input logic [11:0] exp);
        host.recv(fr, ok);
        if (!ok) begin
            n_fail++;
            end_of_test;
        end
        chk({20'h0, fr}, {20'h0, exp});
    endtask
    function automatic logic [11:0] exp_frame(input logic [7:0] d, input logic [1:0] m);
        if (m == 2'h0)
            return {3'b111, d, 1'b0};
        return {2'b11, (m == 2'h1) ? ~^d : ^d, d, 1'b0};
    endfunction
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {hsel, hwrite, haddr, hwdata, htrans, hresetn} = '0;
        hsize = 3'h2;
        repeat (20) @(posedge hclk);
        chk(tx_oe, 1'b0);
        chk(rts_n_oe, 1'b0);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(`RATE_OFS, 32'h1D8);
        rchk(8'h24, 32'h0);
        rchk(`STATUS_OFS, 32'h30);
        xfer(`RATE_OFS, 1'b1, 32'hA00);
        for (int m = 0; m < 3; m++) begin
            xfer(`CTRL_OFS, 1'b1, (m == 2) ? 32'h6 : 32'(m));
            fork
                get_frame(exp_frame(8'hA5 ^ 8'(m), 2'(m)));
                xfer(`TXDATA_OFS, 1'b1, 32'hA5 ^ 32'(m));
            join
        end
        xfer(`IRQ_MASK_OFS, 1'b1, 32'h0);
        repeat (2) @(posedge hclk);
        chk(irq, 1'b0);
        xfer(`IRQ_MASK_OFS, 1'b1, 32'h2);
        repeat (2) @(posedge hclk);
        chk(irq, 1'b1);
        xfer(`IRQ_STAT_OFS, 1'b1, 32'h1F);
        repeat (2) @(posedge hclk);
        chk(irq, 1'b0);
        host.send(exp_frame(8'h3C, 2'h2));
        rchk(`RXDATA_OFS, 32'h3C);
        xfer(`IRQ_STAT_OFS, 1'b0, 32'h0);
        chk(rdv & 32'h5, 32'h1);
        host.send(exp_frame(8'h3C, 2'h1));
        rchk(`RXDATA_OFS, 32'h3C);
        xfer(`IRQ_STAT_OFS, 1'b0, 32'h0);
        chk(rdv & 32'h4, 32'h4);
        xfer(`CTRL_OFS, 1'b1, 32'h8);
        host.send(exp_frame(8'h11, 2'h0));
        chk(rts_n_out, 1'b1);
        rchk(`RXDATA_OFS, 32'h11);
        repeat (2) @(posedge hclk);
        chk(rts_n_out, 1'b0);
        xfer(`TXDATA_OFS, 1'b1, 32'h5A);
        lows = 0;
        repeat (300) begin
            @(posedge hclk);
            lows += (tx_line === 1'b0);
        end
        chk(lows, 0);
        fork
            get_frame(exp_frame(8'h5A, 2'h0));
            host.cts_n <= 1'b0;
        join
        xfer(`CTRL_OFS, 1'b1, 32'h10);
        repeat (4) @(posedge hclk);
        chk(tx_line, 1'b0);
        xfer(`CTRL_OFS, 1'b1, 32'h0);
        xfer(`TMO_OFS, 1'b1, 32'h000003E8);
        host.rx_line <= 1'b0;
        for (n = 0; n < 42000 && break_reset !== 1'b1; n++) @(posedge hclk);
        host.rx_line <= 1'b1;
        chk(n >= 40000 && n < 40200, 1'b1);
        if (n == 42000)
            end_of_test;
        repeat (5) @(posedge hclk);
        rchk(`RATE_OFS, 32'h1D8);
        xfer(`TMO_OFS, 1'b1, 32'h000003E7);
        host.rx_line <= 1'b0;
        lows = 0;
        repeat (41000) begin
            @(posedge hclk);
            lows += (break_reset === 1'b1);
        end
        host.rx_line <= 1'b1;
        chk(lows, 0);
        end_of_test;
    end
endmodule // tb_uart_with_break_reset
bind uart_with_break_reset uart_with_break_reset_chk chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_in(rx_in), .tx_oe(tx_oe), .rts_n_oe(rts_n_oe), .break_reset(break_reset));
